//--- rtl/prm_monitor.sv
// pulse_rate_monitor: speed measurement with window comparison
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module prm_monitor #(
    parameter int W        = prm_pkg::WIDTH,
    parameter int TICK_CYC = prm_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // field inputs
    input  wire logic         measure_en,
    input  wire logic         clear_in,
    input  wire logic         count_in,
    input  wire logic         fast_pulse_input_a,
    input  wire logic         fast_pulse_input_b,
    // register port
    input  wire logic [3:0]   addr,
    input  wire logic [15:0]  wdata,
    input  wire logic         wr,
    input  wire logic         rd,
    output logic      [15:0]  rdata,
    // results
    output logic              out_bit,
    output logic      [W-1:0] speed,
    output logic      [W-1:0] set_period,
    output logic      [W-1:0] cur_period
);
    // elaboration checks: bus, read mux, accumulator and elapsed counter are 16 bits wide
    if (W != 16) begin : g_bad_width
        $error("prm_monitor: W must be 16");
    end
    if (TICK_CYC < 1) begin : g_bad_tick
        $error("prm_monitor: TICK_CYC must be at least 1");
    end

    localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

    prm_cfg_if #(.W(W)) cfg ();

    // timing of one window, in clock cycles:
    //   an input edge reaches the accumulator three cycles after the pin
    //   rises, two for the synchroniser and one for the accumulator register;
    //   a tick marks every TICK_CYC cycles of enabled time;
    //   the boundary is the tick on which elapsed reaches the period;
    //   speed latches on the boundary edge, the comparator one edge later.
    // a pulse seen on the boundary cycle opens the next window, so no
    // pulse is lost or counted twice across windows.
    // the accumulator saturates rather than wrapping; a wrapped count
    // would look like a slow input and could turn the output off.
    // enable low stops the prescaler, so a window paused midway resumes
    // where it stopped instead of starting over.

    // software state
    logic [1:0]   src_sel;
    logic [W-1:0] lower;
    logic [W-1:0] upper;
    logic         sw_clear;
    // measurement state
    logic [TW-1:0] tick_cnt;
    logic [W-1:0]  accum;
    logic [W-1:0]  speed_q;
    logic [W-1:0]  elapsed;
    logic [W-1:0]  period_q;

    // edge detection on each source
    localparam int NSRC = 3;
    wire  [NSRC-1:0] pin_vec;
    logic [NSRC-1:0] rise_vec;

    // pulse lines in source-select order: normal, fast a, fast b
    assign pin_vec = {fast_pulse_input_b, fast_pulse_input_a, count_in};

    // one synchroniser and edge detector per pulse line
    for (genvar g = 0; g < NSRC; g++) begin : g_edge
        prm_edge u_edge (
            .clk  (clk),
            .rst  (rst),
            .din  (pin_vec[g]),
            .rise (rise_vec[g])
        );
    end

    // source select: the sampled edge path copes with kHz rates easily
    // code 3 falls back to the normal input
    wire rise_n = rise_vec[0];
    wire rise_a = rise_vec[1];
    wire rise_b = rise_vec[2];
    wire sel_a  = (src_sel == prm_pkg::SRC_FAST_A);
    wire sel_b  = (src_sel == prm_pkg::SRC_FAST_B);
    wire pulse  = sel_a ? rise_a : (sel_b ? rise_b : rise_n);

    // register map, word addresses:
    //   0 control: source select in the low two bits, clear at bit 2
    //   1 measurement period in ticks, clamped on write
    //   2 lower limit
    //   3 upper limit
    //   4 speed, read only
    //   5 elapsed period, read only
    //   6 status: output at bit 0, measure enable at bit 1
    // writes to read-only or unmapped words are ignored; the clear bit
    // is a one-shot strobe and is never stored, so it reads back zero.
    // register decode
    wire wr_ctrl   = wr && (addr == prm_pkg::ADDR_CTRL);
    wire wr_period = wr && (addr == prm_pkg::ADDR_PERIOD);
    wire wr_lower  = wr && (addr == prm_pkg::ADDR_LOWER);
    wire wr_upper  = wr && (addr == prm_pkg::ADDR_UPPER);

    // out-of-range period is clamped rather than trusted
    wire per_low  = (wdata < prm_pkg::PERIOD_MIN);
    wire per_high = (wdata > prm_pkg::PERIOD_MAX);
    wire [W-1:0] per_clamped =
        per_low  ? prm_pkg::PERIOD_MIN :
        per_high ? prm_pkg::PERIOD_MAX : wdata;

    wire clr       = clear_in | sw_clear;
    wire tick      = (tick_cnt == TICK_LAST);
    wire boundary  = measure_en && tick && (elapsed + 16'h0001 >= period_q);
    wire [W-1:0] accum_inc = (accum == 16'hffff) ? accum : accum + 16'h0001;

    // configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_sel  <= prm_pkg::SRC_NORMAL;
            period_q <= prm_pkg::PERIOD_RST;
            lower    <= '0;
            upper    <= '0;
            sw_clear <= 1'b0;
        end else begin
            sw_clear <= wr_ctrl && wdata[prm_pkg::CTRL_CLEAR];
            if (wr_ctrl) begin
                src_sel <= wdata[prm_pkg::CTRL_SRC_LSB +: 2];
            end
            if (wr_period) begin
                period_q <= per_clamped;
            end
            if (wr_lower) begin
                lower <= wdata;
            end
            if (wr_upper) begin
                upper <= wdata;
            end
        end
    end

    // tick prescaler runs only while measuring, so enable low freezes time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt <= '0;
        end else if (clr) begin
            tick_cnt <= '0;
        end else if (measure_en) begin
            if (tick) begin
                tick_cnt <= '0;
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // elapsed period restarts at each boundary
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elapsed <= '0;
        end else if (clr) begin
            elapsed <= '0;
        end else if (boundary) begin
            elapsed <= '0;
        end else if (measure_en && tick) begin
            elapsed <= elapsed + 16'h0001;
        end
    end

    // accumulator; a pulse on the boundary cycle starts the next window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accum <= '0;
        end else if (clr) begin
            accum <= '0;
        end else if (boundary) begin
            accum <= {15'h0000, pulse};
        end else if (measure_en && pulse) begin
            accum <= accum_inc;
        end
    end

    // speed latch, reloaded at each boundary and zeroed by clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_q <= '0;
        end else if (clr) begin
            speed_q <= '0;
        end else if (boundary) begin
            speed_q <= accum;
        end
    end

    // comparator sees the speed one cycle after latching
    logic load_d;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_d <= 1'b0;
        end else begin
            load_d <= boundary;
        end
    end

    assign cfg.lower = lower;
    assign cfg.upper = upper;
    assign cfg.speed = speed_q;
    assign cfg.load  = load_d & measure_en;
    assign cfg.clear = clr;

    // window comparator holds the output between loads
    prm_compare #(
        .W   (W)
    ) u_cmp (
        .clk (clk),
        .rst (rst),
        .cfg (cfg)
    );

    // read mux; unmapped addresses read zero
    logic [15:0] rd_mux;
    wire  [15:0] ctrl_word = {14'h0000, src_sel};
    wire  [15:0] stat_word = {14'h0000, measure_en, cfg.out};
    always_comb begin
        case (addr)
            prm_pkg::ADDR_CTRL:    rd_mux = ctrl_word;
            prm_pkg::ADDR_PERIOD:  rd_mux = period_q;
            prm_pkg::ADDR_LOWER:   rd_mux = lower;
            prm_pkg::ADDR_UPPER:   rd_mux = upper;
            prm_pkg::ADDR_SPEED:   rd_mux = speed_q;
            prm_pkg::ADDR_ELAPSED: rd_mux = elapsed;
            prm_pkg::ADDR_STATUS:  rd_mux = stat_word;
            default:               rd_mux = 16'h0000;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= 16'h0000;
        end
    end

    assign out_bit    = cfg.out;
    assign speed      = speed_q;
    assign set_period = period_q;
    assign cur_period = elapsed;
endmodule : prm_monitor

//--- rtl/prm_pkg.sv
// shared constants for the pulse rate monitor
package prm_pkg;
    // register offsets (word addresses)
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_PERIOD  = 4'h1;
    localparam logic [3:0] ADDR_LOWER   = 4'h2;
    localparam logic [3:0] ADDR_UPPER   = 4'h3;
    localparam logic [3:0] ADDR_SPEED   = 4'h4;
    localparam logic [3:0] ADDR_ELAPSED = 4'h5;
    localparam logic [3:0] ADDR_STATUS  = 4'h6;
    // control fields
    localparam int CTRL_SRC_LSB = 0;   // 2-bit source select
    localparam int CTRL_CLEAR   = 2;   // write 1: clear pulse
    localparam logic [1:0] SRC_NORMAL = 2'h0;
    localparam logic [1:0] SRC_FAST_A = 2'h1;
    localparam logic [1:0] SRC_FAST_B = 2'h2;
    // status fields
    localparam int STAT_OUT = 0;
    localparam int STAT_EN  = 1;
    // period reset value and clamp limits
    localparam logic [15:0] PERIOD_RST = 16'h0064;
    localparam logic [15:0] PERIOD_MIN = 16'h0001;
    localparam logic [15:0] PERIOD_MAX = 16'h7fff;
    // timing
    localparam int CLK_HZ    = 100_000_000;
    localparam int TICK_MS   = 10;
    localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
    localparam int WIDTH     = 16;
endpackage : prm_pkg

//--- rtl/prm_cfg_if.sv
// configuration and result bundle between the top and the comparator
`timescale 1ns/1ps
interface prm_cfg_if #(parameter int W = 16);
    logic [W-1:0] lower;
    logic [W-1:0] upper;
    logic [W-1:0] speed;
    logic         load;
    logic         clear;
    logic         out;
    modport src (output lower, upper, speed, load, clear, input out);
    modport cmp (input lower, upper, speed, load, clear, output out);
endinterface : prm_cfg_if

//--- rtl/prm_compare.sv
// window comparator with hysteresis for the pulse rate monitor
`timescale 1ns/1ps
module prm_compare #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // values
    prm_cfg_if.cmp    cfg
);
    logic out_q;
    logic next_out;
    wire  up_gt  = cfg.upper > cfg.lower;
    wire  lo_gt  = cfg.lower > cfg.upper;
    wire  sp_le_lo = cfg.speed <= cfg.lower;
    wire  sp_ge_up = cfg.speed >= cfg.upper;
    wire  sp_ge_lo = cfg.speed >= cfg.lower;
    wire  sp_le_up = cfg.speed <= cfg.upper;

    // new state, evaluated only on load; holds otherwise
    always_comb begin
        next_out = out_q;
        if (up_gt) begin
            if (sp_ge_up) next_out = 1'b1;
            else if (sp_le_lo) next_out = 1'b0;
        end else if (lo_gt) begin
            if (sp_le_up) next_out = 1'b1;
            else if (sp_ge_lo) next_out = 1'b0;
        end else begin
            next_out = (cfg.speed == cfg.lower);
        end
    end

    // clear wins over a load in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) out_q <= 1'b0;
        else if (cfg.clear) out_q <= 1'b0;
        else if (cfg.load) out_q <= next_out;
    end

    assign cfg.out = out_q;
endmodule : prm_compare

//--- rtl/prm_edge.sv
// two-stage synchroniser and rising edge detector for a pulse input
`timescale 1ns/1ps
module prm_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pulse
    input  wire logic din,
    output logic      rise
);
    logic s1;
    logic s2;
    logic s3;

    // s1 feeds only s2; the edge is taken between s2 and s3
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign rise = s2 & ~s3;
endmodule : prm_edge

//--- test/prm_src.sv
// stand-in pulse source on the three field inputs
`timescale 1ns/1ps
module prm_src (
    // clock and setup
    input  wire logic       clk,
    input  wire logic [1:0] sel,
    input  wire logic [7:0] half,
    // field pulse lines
    output logic            p_n,
    output logic            p_a,
    output logic            p_b
);
    logic [7:0] cnt = 8'h0;
    logic       sq  = 1'b0;
    logic       tg  = 1'b0;
    // square wave of 2*half cycles on the picked line; idle lines
    // toggle every cycle so a wrong source pick shows as a wrong count
    always @(posedge clk) begin
        cnt <= (cnt + 8'h1 >= half) ? 8'h0 : cnt + 8'h1;
        sq  <= (cnt + 8'h1 >= half) ? ~sq : sq;
        tg  <= ~tg;
    end
    assign p_n = (sel == 2'h1 || sel == 2'h2) ? tg : sq;
    assign p_a = (sel == 2'h1) ? sq : tg;
    assign p_b = (sel == 2'h2) ? sq : tg;
endmodule : prm_src

//--- test/prm_monitor_checker.sv
// port assertions for the pulse rate monitor
`timescale 1ns/1ps
module prm_monitor_checker #(
    parameter int W        = 16,
    parameter int TICK_CYC = 10
) (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst,
    // field and bus inputs
    input wire logic         measure_en,
    input wire logic         clear_in,
    input wire logic [3:0]   addr,
    input wire logic [15:0]  wdata,
    input wire logic         wr,
    input wire logic         rd,
    // results
    input wire logic [15:0]  rdata,
    input wire logic         out_bit,
    input wire logic [W-1:0] speed,
    input wire logic [W-1:0] set_period,
    input wire logic [W-1:0] cur_period
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [W-1:0] lo;
    logic [W-1:0] up;
    // limits are not pins, so they are shadowed from bus writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo <= '0;
            up <= '0;
        end else if (wr && addr == prm_pkg::ADDR_LOWER) begin
            lo <= wdata;
        end else if (wr && addr == prm_pkg::ADDR_UPPER) begin
            up <= wdata;
        end
    end
    // a fresh speed latched while measuring, with no clear near it
    sequence s_new;
        measure_en && !clear_in && !$past(clear_in) && speed != $past(speed);
    endsequence
    property p_clr; clear_in |=> speed == '0 && !out_bit; endproperty
    a_clr: assert property (p_clr) else $error("clear missed");
    property p_frz; !measure_en && !clear_in |=> $stable(speed)
        && $stable(out_bit) && $stable(cur_period); endproperty
    a_frz: assert property (p_frz) else $error("not frozen");
    property p_rdp; rd && addr == prm_pkg::ADDR_PERIOD
        |=> rdata == $past(set_period); endproperty
    a_rdp: assert property (p_rdp) else $error("period read");
    property p_el; cur_period < set_period; endproperty
    a_el: assert property (p_el) else $error("elapsed overrun");
    property p_on; s_new ##0 (up > lo && speed >= up) |=> out_bit; endproperty
    a_on: assert property (p_on) else $error("no turn on");
    property p_inv; s_new ##0 (lo > up && speed >= lo) |=> !out_bit;
    endproperty
    a_inv: assert property (p_inv) else $error("no turn off");
    property p_eq; s_new ##0 (lo == up && speed == lo) |=> out_bit;
    endproperty
    a_eq: assert property (p_eq) else $error("equal not on");
    property p_ne; s_new ##0 (lo == up && speed != lo) |=> !out_bit;
    endproperty
    a_ne: assert property (p_ne) else $error("unequal not off");
endmodule : prm_monitor_checker
bind prm_monitor prm_monitor_checker #(.W(W), .TICK_CYC(TICK_CYC))
    prm_monitor_checker_i (.clk(clk), .rst(rst), .measure_en(measure_en),
    .clear_in(clear_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .out_bit(out_bit), .speed(speed),
    .set_period(set_period), .cur_period(cur_period));

//--- test/prm_monitor_tb.sv
// self-checking bench for the pulse rate monitor
`timescale 1ns/1ps
module prm_monitor_tb;
    localparam int TC = 10;
    typedef struct {logic [15:0] lo, up, sp; logic [7:0] h; logic o;} prm_row_t;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b0, clr = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, cin, fa, fb, out_bit;
    logic [1:0]  sel = 2'h0;
    logic [7:0]  half = 8'h2;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0, rdata, speed, setp, curp, s, c;
    int          errors = 0, n_checks = 0;
    // window of four ticks = 40 cycles; speed = 40 / (2 * half)
    prm_row_t rows [6] = '{'{16'h5, 16'ha, 16'ha, 8'h2, 1'b1},
        '{16'h5, 16'ha, 16'h5, 8'h4, 1'b0}, '{16'ha, 16'h5, 16'h5, 8'h4, 1'b1},
        '{16'ha, 16'h5, 16'ha, 8'h2, 1'b0}, '{16'h4, 16'h4, 16'h4, 8'h5, 1'b1},
        '{16'h4, 16'h4, 16'h5, 8'h4, 1'b0}};
    // 100 MHz clock
    always #5 clk = ~clk;
    prm_monitor #(.TICK_CYC(TC)) prm_monitor_i (.clk(clk), .rst(rst),
        .measure_en(en), .clear_in(clr), .count_in(cin),
        .fast_pulse_input_a(fa), .fast_pulse_input_b(fb), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .out_bit(out_bit),
        .speed(speed), .set_period(setp), .cur_period(curp));
    prm_src prm_src_i (.clk(clk), .sel(sel), .half(half), .p_n(cin),
        .p_a(fa), .p_b(fb));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : chk
    // strobes drop one edge before return so the next call never races
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wreg
    task automatic rchk(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk);
    endtask : rchk
    // waits n edges, then samples off the edge
    task automatic run(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : run
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 chk(setp, 16'h0064);
        chk(speed, 16'h0);
        @(posedge clk);
        wreg(prm_pkg::ADDR_PERIOD, 16'h0);
        rchk(prm_pkg::ADDR_PERIOD, 16'h1);
        wreg(prm_pkg::ADDR_PERIOD, 16'hffff);
        rchk(prm_pkg::ADDR_PERIOD, 16'h7fff);
        rchk(4'hf, 16'h0);
        wreg(prm_pkg::ADDR_PERIOD, 16'h4);
        foreach (rows[i]) begin
            sel <= 2'(i % 3);
            half <= rows[i].h;
            wreg(prm_pkg::ADDR_CTRL, 16'(i % 3));
            wreg(prm_pkg::ADDR_LOWER, rows[i].lo);
            wreg(prm_pkg::ADDR_UPPER, rows[i].up);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            en <= 1'b1;
            run(125);
            chk(speed, rows[i].sp);
            chk(16'(out_bit), 16'(rows[i].o));
            @(posedge clk);
        end
        // faster pulses while disabled must leave everything frozen
        en <= 1'b0;
        half <= 8'h1;
        run(2);
        s = speed;
        c = curp;
        run(100);
        chk(speed, s);
        chk(curp, c);
        @(posedge clk);
        en <= 1'b1;
        run(125);
        chk(speed, 16'h14);
        // on at the upper limit, then held while between the limits
        @(posedge clk);
        wreg(prm_pkg::ADDR_LOWER, 16'h5);
        wreg(prm_pkg::ADDR_UPPER, 16'h14);
        run(125);
        chk(16'(out_bit), 16'h1);
        @(posedge clk);
        half <= 8'h2;
        run(125);
        chk(16'(out_bit), 16'h1);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        rchk(prm_pkg::ADDR_SPEED, 16'h0);
        rchk(prm_pkg::ADDR_ELAPSED, 16'h0);
        rchk(prm_pkg::ADDR_STATUS, 16'h2);
        complete_run();
    end
    // the tests need about 1300 cycles; cut a hang well beyond that
    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule : prm_monitor_tb
